// >>> tls_pkg.sv
// package: constants and types for the trigger layer sequencer
package tls_pkg;
  // layer indices
  localparam int TLS_ARM = 0;
  localparam int TLS_SCAN = 1;
  localparam int TLS_MEAS = 2;
  // control source codes
  localparam logic [2:0] TLS_SRC_IMM = 3'h0;
  localparam logic [2:0] TLS_SRC_HOLD = 3'h1;
  localparam logic [2:0] TLS_SRC_BUS = 3'h2;
  localparam logic [2:0] TLS_SRC_EXT = 3'h3;
  localparam logic [2:0] TLS_SRC_TBUS = 3'h4;
  localparam logic [2:0] TLS_SRC_TIMER = 3'h5;
  localparam logic [2:0] TLS_SRC_CAL = 3'h6;
  // line numbers 1..6, reset values
  localparam logic [2:0] TLS_LINE_MIN = 3'h1;
  localparam logic [2:0] TLS_LINE_MAX = 3'h6;
  localparam logic [2:0] TLS_INPUT_LINE_SELECT_RST = 3'h2;
  localparam logic [2:0] TLS_OUTPUT_LINE_SELECT_RST = 3'h1;
  // calendar limits and reset date
  localparam logic [11:0] TLS_YEAR_MIN = 12'h7ca;
  localparam logic [11:0] TLS_YEAR_MAX = 12'h82d;
  localparam logic [3:0] TLS_MON_MAX = 4'hc;
  localparam logic [4:0] TLS_DAY_MAX = 5'h1f;
  localparam logic [3:0] TLS_MON_FEB = 4'h2;
  localparam logic [11:0] TLS_YEAR_RST = 12'h7ca;
  localparam logic [3:0] TLS_MON_RST = 4'h1;
  localparam logic [4:0] TLS_DAY_RST = 5'h1;
  // output pulse width
  localparam int TLS_PULSE_NS = 10;
  localparam int TLS_CLK_NS = 10;
  localparam int TLS_PULSE_CYC = (TLS_PULSE_NS + TLS_CLK_NS - 1) / TLS_CLK_NS;
  localparam logic [3:0] TLS_PULSE_W = 4'(TLS_PULSE_CYC);
  // layer sequencer states
  typedef enum logic [2:0] {
    TLS_IDLE, TLS_WAIT, TLS_DELAY, TLS_ACT, TLS_DONE
  } tls_state_e;
endpackage : tls_pkg

// >>> tls_pulse.sv
// fixed-width pulse stretcher for one trigger output
`timescale 1ns/100ps
module tls_pulse
  import tls_pkg::*;
(
  // clocking
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // request and pulse
  input wire logic fire_in,
  output logic pulse_out
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;

  // a new request restarts the count, so one exit gives one pulse
  always_comb begin
    next_cnt = cnt;
    if (fire_in) begin
      next_cnt = TLS_PULSE_W;
    end else if (cnt != 4'h0) begin
      next_cnt = cnt - 4'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 4'h0;
      pulse_out <= 1'b0;
    end else if (ce_in) begin
      cnt <= next_cnt;
      pulse_out <= (next_cnt != 4'h0);
    end
  end
endmodule // tls_pulse

// >>> tls_sequencer.sv
// three-layer trigger sequencer: arm, scan and measure
// Operation
// - scan/measure timers pace only while timer is the layer's source
// - arm layer has no timer
// - bypass command skips pending wait; error and ignored if not waiting
// - separate-line mode: measure input and output on distinct lines
// - shared-line mode: measure input and output on one line
// - arm and scan always use separate lines
// - source bypass with external/bus-line source skips first-pass wait
// - scan/measure bypass also skips the layer delay
// - repeat passes (count >1) wait for the event despite bypass
// - first-pass bypass re-arms only after return to previous layer/idle
// - bypass enables arm/scan exit pulse; else no pulse
// - arm/scan pulse on bus output line if bus source, else completion
// - measure pulse always after device action completes
// - wait-for-event setting disables bypass, holds until event
// - input line selectable 1 to 6
// - input line equal to output line: error, keep old value
// - output line equal to input line: error, ignore
// - shared line selectable 1 to 6
// - calendar date years 1994-2093, months 1-12, days 1-31
// - nonexistent date: error, keep stored date
// - timer event fires at interval start and at each expiry
// - calendar source only in arm layer, fires at programmed date/time
`timescale 1ns/100ps
module tls_sequencer
  import tls_pkg::*;
(
  // clocking
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // run control
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic action_done_in,
  output logic action_start_out,
  output logic idle_out,
  // per-layer configuration, index 0 arm, 1 scan, 2 measure
  input wire logic [2:0] src_in [3],
  input wire logic [15:0] count_in [3],
  input wire logic [2:0] bypass_en_in,
  input wire logic [15:0] delay_in [3],
  input wire logic [31:0] timer_in [3],
  input wire logic shared_line_protocol_in,
  // line assignment commands
  input wire logic [2:0] input_line_select_wr_in,
  input wire logic [2:0] output_line_select_wr_in,
  input wire logic [2:0] line_data_in,
  input wire logic shared_line_wr_in,
  // calendar
  input wire logic date_wr_in,
  input wire logic [11:0] year_in,
  input wire logic [3:0] month_in,
  input wire logic [4:0] day_in,
  input wire logic cal_match_in,
  // events
  input wire logic [2:0] signal_in,
  input wire logic bus_trig_in,
  input wire logic ext_trig_in,
  input wire logic [5:0] tbus_in,
  // outputs
  output logic [5:0] tbus_out,
  output logic [5:0] tbus_oe_out,
  output logic completion_out,
  output logic error_out,
  output logic [2:0] input_line_select_out [3],
  output logic [2:0] output_line_select_out [3],
  output logic [2:0] shared_line_out,
  output logic [11:0] year_out,
  output logic [3:0] month_out,
  output logic [4:0] day_out
);
  // day count of a month, leap years by divisibility by four in range
  function automatic logic date_ok(input logic [11:0] y, input logic [3:0] m,
                                   input logic [4:0] d);
    logic [4:0] lim;
    lim = 5'h1f;
    if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hb) begin
      lim = 5'h1e;
    end else if (m == TLS_MON_FEB) begin
      lim = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
    end
    date_ok = (y >= TLS_YEAR_MIN) && (y <= TLS_YEAR_MAX) && (m != 4'h0)
              && (m <= TLS_MON_MAX) && (d != 5'h0) && (d <= TLS_DAY_MAX)
              && (d <= lim);
  endfunction

  function automatic logic line_ok(input logic [2:0] l);
    line_ok = (l >= TLS_LINE_MIN) && (l <= TLS_LINE_MAX);
  endfunction

  // one-hot of a line number 1..6 onto bus bits 0..5
  function automatic logic [5:0] line_bit(input logic [2:0] l);
    line_bit = 6'h01 << (l - 3'h1);
  endfunction

  tls_state_e st [3];
  tls_state_e next_st [3];
  logic [15:0] pass [3];
  logic [15:0] next_pass [3];
  logic [31:0] tmr [3];
  logic [31:0] next_tmr [3];
  logic [15:0] dly [3];
  logic [15:0] next_dly [3];
  logic [2:0] first;
  logic [2:0] next_first;
  logic [2:0] evt;
  logic [2:0] exit_fire;
  logic [2:0] enter;
  logic [2:0] pulse;
  logic [2:0] next_input_line_select [3];
  logic [2:0] next_output_line_select [3];
  logic [2:0] next_shared;
  logic [11:0] next_year;
  logic [3:0] next_month;
  logic [4:0] next_day;
  logic next_err;
  logic next_act;
  logic [5:0] next_tbus;
  logic next_comp;
  logic all_idle;
  logic err_cfg;

  assign all_idle = (st[0] == TLS_IDLE) && (st[1] == TLS_IDLE)
                    && (st[2] == TLS_IDLE);

  // event decode per layer
  always_comb begin
    logic [2:0] il;
    il = 3'h0;
    for (int i = 0; i < 3; i++) begin
      il = (i == TLS_MEAS && shared_line_protocol_in) ? shared_line_out
           : input_line_select_out[i];
      case (src_in[i])
        TLS_SRC_IMM: evt[i] = 1'b1;
        TLS_SRC_BUS: evt[i] = bus_trig_in;
        TLS_SRC_EXT: evt[i] = ext_trig_in;
        TLS_SRC_TBUS: evt[i] = |(tbus_in & line_bit(il));
        TLS_SRC_TIMER: evt[i] = (i != TLS_ARM) && (tmr[i] == 32'h0);
        TLS_SRC_CAL: evt[i] = (i == TLS_ARM) && cal_match_in;
        default: evt[i] = 1'b0;                                 // hold
      endcase
    end
  end

  // layer walking: each layer enters and waits; scan/measure delay; arm/scan hand down
  always_comb begin
    logic byp;
    byp = 1'b0;
    next_err = 1'b0;
    next_first = first;
    exit_fire = 3'h0;
    enter = 3'h0;
    next_act = 1'b0;
    for (int i = 0; i < 3; i++) begin
      next_st[i] = st[i];
      next_pass[i] = pass[i];
      next_dly[i] = dly[i];
      next_tmr[i] = tmr[i];
      // timer runs only when selected; zero means event due now
      if (i != TLS_ARM && src_in[i] == TLS_SRC_TIMER && st[i] != TLS_IDLE)
      begin
        if (tmr[i] == 32'h0 && st[i] == TLS_WAIT) begin
          next_tmr[i] = timer_in[i];
        end else if (tmr[i] != 32'h0) begin
          next_tmr[i] = tmr[i] - 32'h1;
        end
      end
    end
    if (signal_in != 3'h0) begin
      for (int i = 0; i < 3; i++) begin
        if (signal_in[i] && st[i] != TLS_WAIT) begin
          next_err = 1'b1;
        end
      end
    end
    if (abort_in) begin
      for (int i = 0; i < 3; i++) begin
        next_st[i] = TLS_IDLE;
      end
      next_first = 3'h7;
    end else begin
      if (start_in && all_idle) begin
        enter[0] = 1'b1;
      end
      for (int i = 0; i < 3; i++) begin
        byp = bypass_en_in[i] && first[i]
              && (src_in[i] == TLS_SRC_EXT || src_in[i] == TLS_SRC_TBUS);
        case (st[i])
          TLS_WAIT: begin
            if (byp || evt[i] || signal_in[i]) begin
              next_first[i] = 1'b0;
              next_dly[i] = delay_in[i];
              if (i == TLS_ARM) begin
                next_st[i] = TLS_DONE;
              end else if (byp || delay_in[i] == 16'h0) begin
                next_st[i] = (i == TLS_MEAS) ? TLS_ACT : TLS_DONE;
              end else begin
                next_st[i] = TLS_DELAY;
              end
              if (i == TLS_MEAS && (byp || delay_in[i] == 16'h0)) begin
                next_act = 1'b1;
              end
            end
          end
          TLS_DELAY: begin
            if (dly[i] <= 16'h1) begin
              next_st[i] = (i == TLS_MEAS) ? TLS_ACT : TLS_DONE;
              if (i == TLS_MEAS) begin
                next_act = 1'b1;
              end
            end else begin
              next_dly[i] = dly[i] - 16'h1;
            end
          end
          TLS_ACT: begin
            if (action_done_in) begin
              next_st[i] = TLS_DONE;
              exit_fire[i] = 1'b1;
            end
          end
          TLS_DONE: begin
            if (i < TLS_MEAS) begin
              // leaving the layer downward; bypass controls the pulse
              exit_fire[i] = bypass_en_in[i];
              enter[i + 1] = 1'b1;
              next_st[i] = TLS_IDLE;
            end else if (pass[i] + 16'h1 < count_in[i]) begin
              next_pass[i] = pass[i] + 16'h1;
              next_st[i] = TLS_WAIT;
            end else begin
              next_st[i] = TLS_IDLE;
              enter[i - 1] = 1'b1;                              // step back up
            end
          end
          default: ;
        endcase
      end
      // upper layer returning after lower finished: loop or fall idle
      for (int i = 0; i < 2; i++) begin
        if (enter[i] && i == TLS_ARM && !(start_in && all_idle)) begin
          enter[i] = 1'b0;
        end
      end
      if (enter[TLS_SCAN] && st[TLS_MEAS] == TLS_DONE) begin
        // measure layer finished its count: scan loops or ends
        enter[TLS_SCAN] = (pass[TLS_SCAN] + 16'h1 < count_in[TLS_SCAN]);
        next_pass[TLS_SCAN] = pass[TLS_SCAN] + 16'h1;
        next_first[TLS_MEAS] = 1'b1;
        if (!enter[TLS_SCAN]) begin
          next_first[TLS_SCAN] = 1'b1;
          if (pass[TLS_ARM] + 16'h1 < count_in[TLS_ARM]) begin
            next_pass[TLS_ARM] = pass[TLS_ARM] + 16'h1;
            next_st[TLS_ARM] = TLS_WAIT;
          end else begin
            next_first = 3'h7;
          end
        end else begin
          next_st[TLS_SCAN] = TLS_WAIT;
        end
        enter[TLS_SCAN] = 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
        if (enter[i]) begin
          next_st[i] = TLS_WAIT;
          // wait-for-event layers simply never bypass: byp needs bypass_en
          if (i == TLS_ARM) begin
            next_pass[i] = 16'h0;
          end else if (i == TLS_MEAS || st[TLS_MEAS] == TLS_IDLE) begin
            next_pass[i] = 16'h0;
          end
          next_tmr[i] = 32'h0;
        end
      end
    end
  end

  // line, shared line and date commands, accepted only when idle
  always_comb begin
    next_shared = shared_line_out;
    next_year = year_out;
    next_month = month_out;
    next_day = day_out;
    for (int i = 0; i < 3; i++) begin
      next_input_line_select[i] = input_line_select_out[i];
      next_output_line_select[i] = output_line_select_out[i];
      if (input_line_select_wr_in[i] && all_idle) begin
        if (line_ok(line_data_in)
            && line_data_in != output_line_select_out[i]) begin
          next_input_line_select[i] = line_data_in;
        end
      end
      // an output write beside an input write would put both on one line
      if (output_line_select_wr_in[i] && all_idle) begin
        if (line_ok(line_data_in)
            && line_data_in != input_line_select_out[i]
            && !input_line_select_wr_in[i]) begin
          next_output_line_select[i] = line_data_in;
        end
      end
    end
    if (shared_line_wr_in && all_idle && line_ok(line_data_in)) begin
      next_shared = line_data_in;
    end
    if (date_wr_in && all_idle && date_ok(year_in, month_in, day_in)) begin
      next_year = year_in;
      next_month = month_in;
      next_day = day_in;
    end
  end

  // configuration writes rejected while idle raise the error pulse
  always_comb begin
    logic cfg_err;
    cfg_err = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (input_line_select_wr_in[i] && all_idle && (!line_ok(line_data_in)
          || line_data_in == output_line_select_out[i])) begin
        cfg_err = 1'b1;
      end
      if (output_line_select_wr_in[i] && all_idle && (!line_ok(line_data_in)
          || line_data_in == input_line_select_out[i]
          || input_line_select_wr_in[i])) begin
        cfg_err = 1'b1;
      end
    end
    if (shared_line_wr_in && all_idle && !line_ok(line_data_in)) begin
      cfg_err = 1'b1;
    end
    if (date_wr_in && all_idle && !date_ok(year_in, month_in, day_in)) begin
      cfg_err = 1'b1;
    end
    next_comp = 1'b0;
    next_tbus = 6'h0;
    for (int i = 0; i < 3; i++) begin
      if (pulse[i]) begin
        if (i == TLS_MEAS) begin
          next_tbus = next_tbus | line_bit(shared_line_protocol_in
            ? shared_line_out : output_line_select_out[i]);
        end else if (src_in[i] == TLS_SRC_TBUS) begin
          next_tbus = next_tbus | line_bit(output_line_select_out[i]);
        end else begin
          next_comp = 1'b1;
        end
      end
    end
    err_cfg = cfg_err;
  end

  // one stretcher per layer output
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pulse
      tls_pulse u_pulse (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .fire_in(exit_fire[g]),
        .pulse_out(pulse[g])
      );
    end
  endgenerate

  // register every group
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 3; i++) begin
        st[i] <= TLS_IDLE;
        pass[i] <= 16'h0;
        tmr[i] <= 32'h0;
        dly[i] <= 16'h0;
        input_line_select_out[i] <= TLS_INPUT_LINE_SELECT_RST;
        output_line_select_out[i] <= TLS_OUTPUT_LINE_SELECT_RST;
      end
      first <= 3'h7;
      shared_line_out <= TLS_LINE_MIN;
      year_out <= TLS_YEAR_RST;
      month_out <= TLS_MON_RST;
      day_out <= TLS_DAY_RST;
      error_out <= 1'b0;
      action_start_out <= 1'b0;
      idle_out <= 1'b1;
      tbus_out <= 6'h0;
      tbus_oe_out <= 6'h0;
      completion_out <= 1'b0;
    end else if (ce_in) begin
      for (int i = 0; i < 3; i++) begin
        st[i] <= next_st[i];
        pass[i] <= next_pass[i];
        tmr[i] <= next_tmr[i];
        dly[i] <= next_dly[i];
        input_line_select_out[i] <= next_input_line_select[i];
        output_line_select_out[i] <= next_output_line_select[i];
      end
      first <= next_first;
      shared_line_out <= next_shared;
      year_out <= next_year;
      month_out <= next_month;
      day_out <= next_day;
      error_out <= next_err | err_cfg;
      action_start_out <= next_act;
      idle_out <= all_idle;
      tbus_out <= next_tbus;
      tbus_oe_out <= next_tbus;   // open-drain style: drive only when pulsing
      completion_out <= next_comp;
    end
  end
endmodule // tls_sequencer

// >>> tls_sequencer_assertions.sv
// concurrent checks on the trigger layer sequencer ports
`timescale 1ns/100ps
module tls_sequencer_checker
  import tls_pkg::*;
(
  // clocking and requests
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [2:0] input_line_select_wr_in,
  input wire logic [2:0] line_data_in,
  input wire logic date_wr_in,
  input wire logic [3:0] month_in,
  // observed outputs
  input wire logic idle_out,
  input wire logic action_start_out,
  input wire logic error_out,
  input wire logic [5:0] tbus_out,
  input wire logic [5:0] tbus_oe_out,
  input wire logic [2:0] input_line_select_out [3],
  input wire logic [2:0] output_line_select_out [3],
  input wire logic [2:0] shared_line_out,
  input wire logic [11:0] year_out,
  input wire logic [4:0] day_out,
  input wire logic [3:0] month_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // per layer: stored lines legal and never shared between in and out
  for (genvar i = 0; i < 3; i++) begin : g_lay
    a_lines_legal:
      assert property (input_line_select_out[i] inside
        {[TLS_LINE_MIN:TLS_LINE_MAX]} && output_line_select_out[i] inside
        {[TLS_LINE_MIN:TLS_LINE_MAX]}) else $error("line out of range");
    a_lines_distinct:
      assert property (input_line_select_out[i] != output_line_select_out[i])
        else $error("input and output line collide");
  end
  a_shared_range:
    assert property (shared_line_out inside {[TLS_LINE_MIN:TLS_LINE_MAX]})
      else $error("shared line out of range");
  a_date_range:
    assert property (year_out inside {[TLS_YEAR_MIN:TLS_YEAR_MAX]} &&
      month_out inside {[4'h1:TLS_MON_MAX]} &&
      day_out inside {[5'h1:TLS_DAY_MAX]}) else $error("stored date illegal");
  // idle for two samples and no start: the write cannot race a run
  a_bad_line_err:
    assert property (idle_out && $past(idle_out) && !$past(start_in) &&
      ce_in && input_line_select_wr_in != 3'h0 && !(line_data_in inside {[3'h1:3'h6]})
      |=> error_out) else $error("bad line accepted silently");
  a_bad_date_kept:
    assert property (idle_out && $past(idle_out) && !$past(start_in) &&
      ce_in && date_wr_in && month_in == 4'h0 |=> error_out &&
      $stable(year_out)) else $error("bad date not refused");
  a_busy_frozen:
    assert property (!idle_out ##1 !idle_out |-> $stable(year_out) &&
      $stable(shared_line_out)) else $error("config moved while running");
  a_drive_enabled:
    assert property ($onehot0(tbus_out) && tbus_oe_out == tbus_out)
      else $error("bus pulse without enable");
  a_action_busy:
    assert property (action_start_out |-> !idle_out)
      else $error("action started while idle");
  // main scenarios reached
  c_action: cover property (action_start_out);
  c_error: cover property (error_out);
  c_bus_pulse: cover property (|(tbus_out & tbus_oe_out));
endmodule // tls_sequencer_checker

// >>> tls_bus_partner.sv
// model of the other instruments sharing the six trigger bus lines
`timescale 1ns/100ps
module tls_bus_partner
  import tls_pkg::*;
(
  // clocking
  input wire logic clk_in,
  input wire logic rst_in,
  // bench command: pulse one line
  input wire logic fire_in,
  input wire logic [2:0] line_in,
  // device side of the bus
  input wire logic [5:0] tbus_out_in,
  input wire logic [5:0] tbus_oe_in,
  output logic [5:0] tbus_level_out,
  output logic [7:0] seen_out
);
  logic [5:0] drive;
  logic [5:0] dev_hi;
  logic dev_prev;
  // device wins where enabled; released lines rest at the pull-down level
  assign dev_hi = tbus_out_in & tbus_oe_in;
  assign tbus_level_out = dev_hi | (drive & ~tbus_oe_in);
  // one-cycle pulse on line 1..6, and count pulses the device sends
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive <= 6'h0;
      dev_prev <= 1'b0;
      seen_out <= 8'h0;
    end else begin
      drive <= fire_in ? 6'h1 << (line_in - 3'h1) : 6'h0;
      dev_prev <= |dev_hi;
      if (|dev_hi && !dev_prev) seen_out <= seen_out + 8'h1;
    end
  end
endmodule // tls_bus_partner

// >>> test_tls_sequencer.sv
// self-checking bench for the trigger layer sequencer
`timescale 1ns/100ps
module test_tls_sequencer;
  import tls_pkg::*;
  typedef struct {logic [1:0] k; int l; logic [2:0] d; logic e;
    logic [2:0] v;} tls_lrow_s;
  typedef struct {logic [11:0] y; logic [3:0] m; logic [4:0] d;
    logic e;} tls_drow_s;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic start, abort, done, shared_wr, date_wr, ext, fire, shp, cal;
  logic [2:0] src [3], byp, iwr, owr, ldata, sig, fline;
  logic [15:0] cnt [3], dly [3];
  logic [31:0] tmr [3];
  logic [11:0] yr, yo;
  logic [3:0] mo, mo_o;
  logic [4:0] dy, dy_o;
  logic act, idle, compl, err;
  logic [5:0] tb_o, tb_oe, tb_lvl;
  logic [2:0] il [3], ol [3], shl;
  logic [7:0] seen;
  int err_count = 0;
  int checks = 0;
  int ncompl, nact;
  tls_drow_s keep;
  // kind 0 input, 1 output, 2 shared; layer; line; error; stored value
  tls_lrow_s lrow [10] = '{'{0,0,3,0,3}, '{1,0,3,1,1}, '{0,1,1,1,2},
    '{0,2,0,1,2}, '{0,2,7,1,2}, '{1,2,6,0,6}, '{0,2,6,1,2},
    '{2,0,6,0,6}, '{2,0,0,1,6}, '{1,1,4,0,4}};
  // 1996-2-29, 1994-2-29, 2094-1-1, 2093-12-31, 2000-13-1, 1993, day 0,
  // month 0
  tls_drow_s drow [8] = '{'{12'h7cc,4'h2,5'h1d,0}, '{12'h7ca,4'h2,5'h1d,1},
    '{12'h82e,4'h1,5'h1,1}, '{12'h82d,4'hc,5'h1f,0},
    '{12'h7d0,4'hd,5'h1,1}, '{12'h7c9,4'h5,5'h5,1}, '{12'h7d1,4'h4,5'h0,1},
    '{12'h7d0,4'h0,5'h1,1}};

  always #5 clk_in = ~clk_in;

  tls_sequencer u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .start_in(start), .abort_in(abort), .action_done_in(done),
    .action_start_out(act), .idle_out(idle), .src_in(src), .count_in(cnt),
    .bypass_en_in(byp), .delay_in(dly), .timer_in(tmr),
    .shared_line_protocol_in(shp), .input_line_select_wr_in(iwr), .output_line_select_wr_in(owr),
    .line_data_in(ldata), .shared_line_wr_in(shared_wr),
    .date_wr_in(date_wr), .year_in(yr), .month_in(mo), .day_in(dy),
    .cal_match_in(cal), .signal_in(sig), .bus_trig_in(1'b0),
    .ext_trig_in(ext), .tbus_in(tb_lvl), .tbus_out(tb_o),
    .tbus_oe_out(tb_oe), .completion_out(compl), .error_out(err),
    .input_line_select_out(il), .output_line_select_out(ol),
    .shared_line_out(shl), .year_out(yo), .month_out(mo_o), .day_out(dy_o));

  tls_bus_partner u_bus (.clk_in(clk_in), .rst_in(rst_in), .fire_in(fire),
    .line_in(fline), .tbus_out_in(tb_o), .tbus_oe_in(tb_oe),
    .tbus_level_out(tb_lvl), .seen_out(seen));

  // pulse counters; pulses stand one cycle so every edge is sampled
  always @(posedge clk_in) begin
    if (compl === 1'b1) ncompl++;
    if (act === 1'b1) nact++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checks++;
    if (seen_v !== exp_v) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // bounded wait on idle (0) or action start (1)
  task automatic wait_for(input int which);
    int i;
    for (i = 0; i < 300 && (which ? act : idle) !== 1'b1; i++) tick(1);
    if (i == 300) begin
      err_count++;
      give_verdict();
    end
  endtask

  task automatic wr_line(input tls_lrow_s r);
    ldata = r.d;
    if (r.k == 0) iwr[r.l] = 1'b1;
    else if (r.k == 1) owr[r.l] = 1'b1;
    else shared_wr = 1'b1;
    tick(1);
    iwr = 3'h0;
    owr = 3'h0;
    shared_wr = 1'b0;
    chk(err, r.e);
    tick(1);
  endtask

  // one pass through all layers; ev 1 bypass, 2 external, 3 bus line,
  // 4 calendar
  task automatic run(input logic [2:0] s0, s1, b, input int ev, ec, es);
    logic [7:0] s0_seen;
    src[0] = s0;
    src[1] = s1;
    byp = b;
    s0_seen = seen;
    ncompl = 0;
    nact = 0;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    if (ev != 0) begin
      tick(8);
      chk(nact, 0); // held waiting for its event
      if (ev == 1) sig[0] = 1'b1;
      else if (ev == 2) ext = 1'b1;
      else if (ev == 3) fire = 1'b1;
      else cal = 1'b1;
      tick(1);
      sig = 3'h0;
      ext = 1'b0;
      fire = 1'b0;
      cal = 1'b0;
    end
    wait_for(1);
    tick(2);
    done = 1'b1;
    tick(1);
    done = 1'b0;
    wait_for(0);
    tick(4);
    chk(ncompl, ec);
    chk(seen - s0_seen, es);
  endtask

  initial begin
    {start, abort, done, shared_wr, date_wr, ext, fire, shp, cal} = 9'h0;
    {byp, iwr, owr, sig} = 12'h0;
    ldata = 3'h1;
    fline = 3'h3;
    yr = TLS_YEAR_RST;
    mo = TLS_MON_RST;
    dy = TLS_DAY_RST;
    for (int i = 0; i < 3; i++) begin
      src[i] = TLS_SRC_IMM;
      cnt[i] = 16'h1;
      dly[i] = 16'h2;
      tmr[i] = 32'h3;
    end
    tick(5);
    rst_in = 1'b0;
    chk({il[0], ol[0], shl, yo, mo_o, dy_o}, {TLS_INPUT_LINE_SELECT_RST, TLS_OUTPUT_LINE_SELECT_RST,
      3'h1, TLS_YEAR_RST, TLS_MON_RST, TLS_DAY_RST});
    foreach (lrow[i]) begin
      wr_line(lrow[i]);
      case (lrow[i].k)
        0: chk(il[lrow[i].l], lrow[i].v);
        1: chk(ol[lrow[i].l], lrow[i].v);
        default: chk(shl, lrow[i].v);
      endcase
    end
    keep = drow[0];
    // strobe held high: every edge takes the next row
    date_wr = 1'b1;
    foreach (drow[i]) begin
      {yr, mo, dy} = {drow[i].y, drow[i].m, drow[i].d};
      tick(1);
      chk(err, drow[i].e);
      if (!drow[i].e) keep = drow[i];
      chk({yo, mo_o, dy_o}, {keep.y, keep.m, keep.d});
    end
    date_wr = 1'b0;
    // measure pulse goes to its bus line, arm/scan to completion unless bus-line source
    run(TLS_SRC_IMM, TLS_SRC_IMM, 3'h0, 0, 0, 1);
    run(TLS_SRC_IMM, TLS_SRC_IMM, 3'h3, 0, 2, 1);
    run(TLS_SRC_HOLD, TLS_SRC_IMM, 3'h0, 1, 0, 1);
    run(TLS_SRC_TBUS, TLS_SRC_IMM, 3'h1, 0, 0, 2);
    run(TLS_SRC_TBUS, TLS_SRC_IMM, 3'h0, 3, 0, 1);
    run(TLS_SRC_EXT, TLS_SRC_IMM, 3'h0, 2, 0, 1);
    run(TLS_SRC_IMM, TLS_SRC_TIMER, 3'h0, 0, 0, 1);
    run(TLS_SRC_TIMER, TLS_SRC_IMM, 3'h0, 1, 0, 1);
    run(TLS_SRC_CAL, TLS_SRC_IMM, 3'h0, 4, 0, 1);
    // shared line: measure waits on the common line 6
    shp = 1'b1;
    src[2] = TLS_SRC_TBUS;
    fline = 3'h6;
    run(TLS_SRC_IMM, TLS_SRC_IMM, 3'h0, 3, 0, 1);
    shp = 1'b0;
    src[2] = TLS_SRC_IMM;
    fline = 3'h3;
    // abort while waiting, then a bypass command with nothing pending
    src[0] = TLS_SRC_EXT;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    // a line write while busy is dropped without error
    ldata = 3'h2;
    shared_wr = 1'b1;
    tick(1);
    shared_wr = 1'b0;
    chk(err, 1'b0);
    tick(3);
    chk(shl, 3'h6);
    abort = 1'b1;
    tick(1);
    abort = 1'b0;
    tick(3);
    chk(idle, 1'b1);
    sig[0] = 1'b1;
    tick(1);
    sig = 3'h0;
    chk(err, 1'b1);
    // second reset in mid-run restores the line defaults
    src[0] = TLS_SRC_HOLD;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(3);
    rst_in = 1'b1;
    tick(2);
    rst_in = 1'b0;
    chk({idle, il[0], ol[1]}, {1'b1, TLS_INPUT_LINE_SELECT_RST, TLS_OUTPUT_LINE_SELECT_RST});
    give_verdict();
  end
endmodule // test_tls_sequencer

bind tls_sequencer tls_sequencer_checker u_chk (.clk_in, .rst_in, .ce_in,
  .start_in, .input_line_select_wr_in, .line_data_in, .date_wr_in, .month_in, .idle_out,
  .action_start_out, .error_out, .tbus_out, .tbus_oe_out,
  .input_line_select_out, .output_line_select_out, .shared_line_out,
  .year_out, .day_out, .month_out);
